// file: verilog/t8oc_pkg.sv
// constants, types and bus carriers shared by the output compare unit
//
// Overview of operation
// - compare the 8-bit count with the active compare value every cycle
// - a match sets the compare flag on the following timer clock edge
// - interrupt only with flag set, channel enable one and global enable set
// - the flag clears when the processor executes the compare interrupt
// - writing one to the flag bit clears it, writing zero does nothing
// - output state follows match, mode, action, plus max and bottom cases
// - compare value double buffered in pwm modes, direct in normal and ctc
// - buffered value moves to the active register only at top (count at max)
// - processor reaches the buffer when buffering, the active value otherwise
// - in non-pwm modes a force strobe applies the action like a match
// - a forced compare neither sets the flag nor touches the counter
// - a count write blocks matches in the next timer cycle, stopped or not
// - output state keeps its value across waveform mode changes
// - output action is not buffered and governs the very next match
// - system reset clears the output state to zero
// - nonzero action puts output state on the pin instead of port latch
// - pin direction stays with the direction bit, state shows only as output
// - action zero leaves the output state alone on matches in every mode
// - output action never alters the counting sequence
// - action picks polarity in pwm, set clear or toggle in non-pwm
// - mode codes: normal 0, phase correct 1, clear on match 2, fast 3
// - action one toggles on each match in non-pwm and fast pwm
`default_nettype none
package t8oc_pkg;

    // register offsets (byte addresses on the bus)
    localparam logic [11:0] T8OC_CTRL_OFS = 12'h000;
    localparam logic [11:0] T8OC_COMPARE_OFS = 12'h004;
    localparam logic [11:0] T8OC_COUNT_OFS = 12'h008;
    localparam logic [11:0] T8OC_STATUS_OFS = 12'h00C;
    localparam logic [11:0] T8OC_ACTIVE_OFS = 12'h010;

    // control register field positions
    localparam int T8OC_CTRL_MODE_LSB = 0;
    localparam int T8OC_CTRL_ACTION_LSB = 2;
    localparam int T8OC_CTRL_FORCE_BIT = 4;
    localparam int T8OC_CTRL_IRQEN_BIT = 5;
    localparam int T8OC_CTRL_DIR_BIT = 6;
    localparam int T8OC_CTRL_LATCH_BIT = 7;

    // status register field positions
    localparam int T8OC_STATUS_FLAG_BIT = 0;
    localparam int T8OC_STATUS_OCS_BIT = 1;
    localparam int T8OC_STATUS_BLOCK_BIT = 2;

    // reset values
    localparam logic [7:0] T8OC_COMPARE_RST = 8'h00;
    localparam logic T8OC_OCS_RST = 1'b0;

    // waveform modes
    typedef enum logic [1:0] {
        T8OC_MODE_NORMAL = 2'h0,
        T8OC_MODE_PC_PWM = 2'h1,
        T8OC_MODE_CTC = 2'h2,
        T8OC_MODE_FAST_PWM = 2'h3
    } t8oc_mode_t;

    // compare output actions
    typedef enum logic [1:0] {
        T8OC_ACT_NONE = 2'h0,
        T8OC_ACT_TOGGLE = 2'h1,
        T8OC_ACT_CLEAR = 2'h2,
        T8OC_ACT_SET = 2'h3
    } t8oc_action_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } t8oc_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } t8oc_apb_rsp_t;

    // status from the counter unit
    typedef struct packed {
        logic [7:0] count;
        logic tick;
        logic at_max;
        logic at_bottom;
        logic down;
    } t8oc_cnt_t;

    // count load request to the counter unit
    typedef struct packed {
        logic strobe;
        logic [7:0] value;
    } t8oc_load_t;

    // pin drive: value and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } t8oc_pin_t;

endpackage
`default_nettype wire

// file: verilog/t8oc_comparator.sv
// 8-bit equality comparator between running count and compare value
`timescale 1ns/1ps
`default_nettype none
module t8oc_comparator (
    input wire logic [7:0] count,
    input wire logic [7:0] compare,
    output logic match
);
    // continuous equality check
    assign match = (count == compare);
endmodule // t8oc_comparator
`default_nettype wire

// file: verilog/t8oc_pin_mux.sv
// port pin override: output state or port latch, direction kept apart
`timescale 1ns/1ps
`default_nettype none
module t8oc_pin_mux (
    input wire logic clk,
    input wire logic rst,
    input wire logic override,
    input wire logic state,
    input wire logic latch,
    input wire logic direction,
    output t8oc_pkg::t8oc_pin_t pin
);
    import t8oc_pkg::*;

    t8oc_pin_t r;
    t8oc_pin_t next_r;

    // choose the pin source, whatever the waveform mode
    always_comb begin
        next_r = r;
        next_r.out = override ? state : latch;
        next_r.oe = direction;
    end

    // register the pin drive
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pin = r;
endmodule // t8oc_pin_mux
`default_nettype wire

// file: verilog/t8oc_unit.sv
// output compare unit of the 8-bit timer with its apb register file
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module t8oc_unit (
    input wire logic clk,
    input wire logic rst,
    input wire t8oc_pkg::t8oc_apb_req_t apb_req,
    output t8oc_pkg::t8oc_apb_rsp_t apb_rsp,
    input wire t8oc_pkg::t8oc_cnt_t cnt,
    output t8oc_pkg::t8oc_load_t count_load,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    output logic compare_irq,
    output t8oc_pkg::t8oc_pin_t pin,
    output logic compare_output_state
);
    import t8oc_pkg::*;

    // whole state of the unit
    typedef struct packed {
        t8oc_mode_t mode;
        t8oc_action_t action;
        logic irq_en;
        logic pin_dir;
        logic port_latch;
        logic [7:0] active_cmp;
        logic [7:0] buffer_cmp;
        logic flag;
        logic ocs;
        logic block;
        logic irq;
        t8oc_load_t load;
        t8oc_apb_rsp_t rsp;
    } t8oc_state_t;

    t8oc_state_t r;
    t8oc_state_t next_r;

    logic match;
    logic setup;
    logic access;
    logic wr;
    logic wr_ctrl;
    logic wr_compare;
    logic wr_count;
    logic wr_status;
    logic mapped;
    logic buffered;
    logic pwm_new;
    logic force_now;
    logic match_ev;
    logic top_ev;
    logic flag_clr;
    logic [31:0] rdata;
    t8oc_mode_t wmode;
    t8oc_action_t waction;

    // comparator between running count and active compare value
    t8oc_comparator u_cmp (
        .count(cnt.count),
        .compare(r.active_cmp),
        .match(match)
    );

    // pin override and direction
    t8oc_pin_mux u_pin (
        .clk(clk),
        .rst(rst),
        .override(r.action != T8OC_ACT_NONE),
        .state(r.ocs),
        .latch(r.port_latch),
        .direction(r.pin_dir),
        .pin(pin)
    );

    // apb phase decode: setup cycle and the access edge with pready high
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & r.rsp.pready;
    assign wr = access & apb_req.pwrite & ~r.rsp.pslverr;
    assign wr_ctrl = wr & (apb_req.paddr == T8OC_CTRL_OFS);
    assign wr_compare = wr & (apb_req.paddr == T8OC_COMPARE_OFS);
    assign wr_count = wr & (apb_req.paddr == T8OC_COUNT_OFS);
    assign wr_status = wr & (apb_req.paddr == T8OC_STATUS_OFS);

    // known register addresses
    assign mapped = (apb_req.paddr == T8OC_CTRL_OFS)
        | (apb_req.paddr == T8OC_COMPARE_OFS)
        | (apb_req.paddr == T8OC_COUNT_OFS)
        | (apb_req.paddr == T8OC_STATUS_OFS)
        | (apb_req.paddr == T8OC_ACTIVE_OFS);

    // buffering is on in both pwm modes only
    assign buffered = (r.mode == T8OC_MODE_PC_PWM)
        | (r.mode == T8OC_MODE_FAST_PWM);

    // mode and action as seen by a control write in this cycle
    assign wmode = t8oc_mode_t'(
        apb_req.pwdata[T8OC_CTRL_MODE_LSB +: 2]);
    assign waction = t8oc_action_t'(
        apb_req.pwdata[T8OC_CTRL_ACTION_LSB +: 2]);
    assign pwm_new = (wmode == T8OC_MODE_PC_PWM)
        | (wmode == T8OC_MODE_FAST_PWM);

    // force strobe only acts in the non-pwm modes
    assign force_now = wr_ctrl & apb_req.pwdata[T8OC_CTRL_FORCE_BIT]
        & ~pwm_new;

    // a real match, taken on a timer clock and not blocked by a count write
    assign match_ev = cnt.tick & match & ~r.block & ~wr_count;

    // top of the sequence, where buffered values are loaded
    assign top_ev = cnt.tick & cnt.at_max;

    // flag clear by write-one or by interrupt execution
    assign flag_clr = (wr_status & apb_req.pwdata[T8OC_STATUS_FLAG_BIT])
        | compare_irq_ack;

    // read data mux, sampled in the setup cycle
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (apb_req.paddr)
            T8OC_CTRL_OFS: begin
                rdata[T8OC_CTRL_MODE_LSB +: 2] = r.mode;
                rdata[T8OC_CTRL_ACTION_LSB +: 2] = r.action;
                rdata[T8OC_CTRL_IRQEN_BIT] = r.irq_en;
                rdata[T8OC_CTRL_DIR_BIT] = r.pin_dir;
                rdata[T8OC_CTRL_LATCH_BIT] = r.port_latch;
            end
            T8OC_COMPARE_OFS: begin
                rdata[7:0] = buffered ? r.buffer_cmp : r.active_cmp;
            end
            T8OC_COUNT_OFS: begin
                rdata[7:0] = cnt.count;
            end
            T8OC_STATUS_OFS: begin
                rdata[T8OC_STATUS_FLAG_BIT] = r.flag;
                rdata[T8OC_STATUS_OCS_BIT] = r.ocs;
                rdata[T8OC_STATUS_BLOCK_BIT] = r.block;
            end
            T8OC_ACTIVE_OFS: begin
                rdata[7:0] = r.active_cmp;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // next state of the whole unit
    always_comb begin
        next_r = r;

        // bus answer: one access cycle with pready high, then released
        next_r.rsp.pready = setup;
        next_r.rsp.pslverr = setup & ~mapped;
        if (setup) begin
            next_r.rsp.prdata = (apb_req.pwrite | ~mapped) ?
                32'h0000_0000 : rdata;
        end

        // control writes; action takes effect at once, unbuffered
        if (wr_ctrl) begin
            next_r.mode = wmode;
            next_r.action = waction;
            next_r.irq_en = apb_req.pwdata[T8OC_CTRL_IRQEN_BIT];
            next_r.pin_dir = apb_req.pwdata[T8OC_CTRL_DIR_BIT];
            next_r.port_latch = apb_req.pwdata[T8OC_CTRL_LATCH_BIT];
        end

        // compare writes go to the buffer or straight to the comparator
        if (wr_compare) begin
            next_r.buffer_cmp = apb_req.pwdata[7:0];
            if (!buffered) begin
                next_r.active_cmp = apb_req.pwdata[7:0];
            end
        end

        // buffered value reaches the comparator only at top
        if (buffered && top_ev) begin
            next_r.active_cmp = r.buffer_cmp;
        end

        // count write: load request to the counter and block one timer cycle
        // a tick under the pending load is overridden by it, so the block
        // lasts until the first tick that sees the new count
        next_r.load.strobe = wr_count;
        if (wr_count) begin
            next_r.load.value = apb_req.pwdata[7:0];
            next_r.block = 1'b1;
        end else if (cnt.tick && !r.load.strobe) begin
            next_r.block = 1'b0;
        end

        // compare flag: a match wins over a clear in the same cycle
        next_r.flag = (r.flag & ~flag_clr) | match_ev;

        // interrupt request line
        next_r.irq = next_r.flag & r.irq_en & global_irq_enable;

        // waveform generator acting on the output state
        unique case (r.mode)
            T8OC_MODE_NORMAL, T8OC_MODE_CTC: begin
                // non-pwm: set, clear or toggle on match
                if (match_ev) begin
                    unique case (r.action)
                        T8OC_ACT_NONE: next_r.ocs = r.ocs;
                        T8OC_ACT_TOGGLE: next_r.ocs = ~r.ocs;
                        T8OC_ACT_CLEAR: next_r.ocs = 1'b0;
                        T8OC_ACT_SET: next_r.ocs = 1'b1;
                    endcase
                end
            end
            T8OC_MODE_FAST_PWM: begin
                // fast pwm: top restarts the period, top wins a tie
                unique case (r.action)
                    T8OC_ACT_NONE: next_r.ocs = r.ocs;
                    T8OC_ACT_TOGGLE: begin
                        if (match_ev) begin
                            next_r.ocs = ~r.ocs;
                        end
                    end
                    T8OC_ACT_CLEAR: begin
                        if (top_ev) begin
                            next_r.ocs = 1'b1;
                        end else if (match_ev) begin
                            next_r.ocs = 1'b0;
                        end
                    end
                    T8OC_ACT_SET: begin
                        if (top_ev) begin
                            next_r.ocs = 1'b0;
                        end else if (match_ev) begin
                            next_r.ocs = 1'b1;
                        end
                    end
                endcase
            end
            T8OC_MODE_PC_PWM: begin
                // phase correct: direction picks clear or set
                if (match_ev) begin
                    unique case (r.action)
                        T8OC_ACT_NONE: next_r.ocs = r.ocs;
                        T8OC_ACT_TOGGLE: next_r.ocs = r.ocs;
                        T8OC_ACT_CLEAR: next_r.ocs = cnt.down;
                        T8OC_ACT_SET: next_r.ocs = ~cnt.down;
                    endcase
                end else if (cnt.tick && cnt.at_bottom
                        && r.active_cmp == 8'h00) begin
                    // extreme compare of zero holds the idle level
                    if (r.action == T8OC_ACT_CLEAR) begin
                        next_r.ocs = 1'b1;
                    end else if (r.action == T8OC_ACT_SET) begin
                        next_r.ocs = 1'b0;
                    end
                end
            end
        endcase

        // forced compare: only the output state, no flag, no counter
        if (force_now) begin
            unique case (waction)
                T8OC_ACT_NONE: next_r.ocs = r.ocs;
                T8OC_ACT_TOGGLE: next_r.ocs = ~r.ocs;
                T8OC_ACT_CLEAR: next_r.ocs = 1'b0;
                T8OC_ACT_SET: next_r.ocs = 1'b1;
            endcase
        end
    end

    // state register; system reset clears the output state
    always_ff @(posedge clk) begin
        if (rst) begin
            r.mode <= T8OC_MODE_NORMAL;
            r.action <= T8OC_ACT_NONE;
            r.irq_en <= 1'b0;
            r.pin_dir <= 1'b0;
            r.port_latch <= 1'b0;
            r.active_cmp <= T8OC_COMPARE_RST;
            r.buffer_cmp <= T8OC_COMPARE_RST;
            r.flag <= 1'b0;
            r.ocs <= T8OC_OCS_RST;
            r.block <= 1'b0;
            r.irq <= 1'b0;
            r.load <= '0;
            r.rsp <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign apb_rsp = r.rsp;
    assign count_load = r.load;
    assign compare_irq = r.irq;
    assign compare_output_state = r.ocs;
endmodule // t8oc_unit
`default_nettype wire

// file: verif/t8oc_cnt_model.sv
// counter unit model: up counter stepped by a run enable
`timescale 1ns/1ps
`default_nettype none
module t8oc_cnt_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire t8oc_pkg::t8oc_load_t load,
    output t8oc_pkg::t8oc_cnt_t cnt
);
    import t8oc_pkg::*;
    logic [7:0] count;
    // a processor load wins over counting
    always_ff @(posedge clk) begin
        if (rst)
            count <= 8'h00;
        else if (load.strobe)
            count <= load.value;
        else if (run)
            count <= count + 8'h01;
    end
    // status seen by the compare unit, tick only while running
    assign cnt = '{count: count, tick: run, at_max: count == 8'hFF,
                  at_bottom: count == 8'h00, down: 1'b0};
endmodule // t8oc_cnt_model
`default_nettype wire

// file: verif/t8oc_checker.sv
// assertions on the ports of the output compare unit
`timescale 1ns/1ps
`default_nettype none
module t8oc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire t8oc_pkg::t8oc_apb_req_t apb_req,
    input wire t8oc_pkg::t8oc_apb_rsp_t apb_rsp,
    input wire t8oc_pkg::t8oc_cnt_t cnt,
    input wire t8oc_pkg::t8oc_load_t count_load,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic compare_irq,
    input wire t8oc_pkg::t8oc_pin_t pin,
    input wire logic compare_output_state
);
    import t8oc_pkg::*;
    logic setup;
    logic acc;
    logic cnt_wr;
    logic frc_wr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // bus phases decoded from the ports
    assign setup = apb_req.psel && !apb_req.penable;
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign cnt_wr = acc && apb_req.pwrite && apb_req.paddr == T8OC_COUNT_OFS;
    assign frc_wr = acc && apb_req.pwrite && apb_req.paddr == T8OC_CTRL_OFS
        && apb_req.pwdata[T8OC_CTRL_FORCE_BIT];
    chk_ready_next: assert property (setup |=> apb_rsp.pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    chk_unmapped_err: assert property (
        acc && apb_req.paddr > T8OC_ACTIVE_OFS |-> apb_rsp.pslverr
        && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
    chk_load_pulse: assert property (cnt_wr |=> count_load.strobe
        && count_load.value == $past(apb_req.pwdata[7:0]))
        else $error("count load missing");
    chk_load_only: assert property (
        count_load.strobe |-> $past(cnt_wr))
        else $error("load without count write");
    chk_irq_gate: assert property (
        compare_irq |-> $past(global_irq_enable))
        else $error("irq without global enable");
    chk_ocs_cause: assert property (
        $changed(compare_output_state)
        |-> $past(cnt.tick) || $past(frc_wr) || $past(frc_wr, 2)
        || $past(rst)) else $error("output state changed without cause");
    chk_ack_clear: assert property (
        compare_irq_ack && !cnt.tick |=> !compare_irq)
        else $error("ack did not clear irq");
    cover property (frc_wr);
    cover property ($rose(compare_irq));
    cover property (acc && apb_rsp.pslverr);
endmodule // t8oc_checker
bind t8oc_unit t8oc_checker t8oc_checker_inst (.clk, .rst, .apb_req,
    .apb_rsp, .cnt, .count_load, .global_irq_enable, .compare_irq_ack,
    .compare_irq, .pin, .compare_output_state);
`default_nettype wire

// file: verif/t8oc_unit_tb.sv
// register-level testbench for the output compare unit
`timescale 1ns/1ps
`default_nettype none
module t8oc_unit_tb;
    import t8oc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic irq;
    logic ocs;
    logic e;
    logic serr;
    logic [31:0] rd;
    logic [31:0] exp_st;
    t8oc_apb_req_t req = '0;
    t8oc_apb_rsp_t rsp;
    t8oc_cnt_t cnt;
    t8oc_load_t load;
    t8oc_pin_t pin;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    t8oc_unit t8oc_unit_inst (.clk(clk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .cnt(cnt), .count_load(load),
        .global_irq_enable(gie), .compare_irq_ack(ack), .compare_irq(irq),
        .pin(pin), .compare_output_state(ocs));
    t8oc_cnt_model t8oc_cnt_model_inst (.clk(clk), .rst(rst), .run(run),
        .load(load), .cnt(cnt));
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic chk_bit(string n, logic x, logic g);
        chk(n, {31'h0, x}, {31'h0, g});
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1)
            @(posedge clk);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(string n, logic [11:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, x, rd);
    endtask
    // n timer ticks, then time for the pin flop to follow
    task automatic step(int n);
        @(posedge clk);
        run <= 1'b1;
        repeat (n) @(posedge clk);
        run <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [31:0] ctrl(logic [1:0] m, logic [1:0] a,
        logic f, logic l);
        return {24'h0, l, 1'b1, 1'b1, f, a, m};
    endfunction
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk("ctrl", T8OC_CTRL_OFS, 32'h0);
        rchk("cmp", T8OC_COMPARE_OFS, {24'h0, T8OC_COMPARE_RST});
        rchk("status", T8OC_STATUS_OFS, 32'h0);
        chk_bit("pin oe", 1'b0, pin.oe);
        apb(1'b0, 12'h040, 32'h0);
        chk_bit("slverr", 1'b1, serr);
        wr(T8OC_CTRL_OFS, ctrl(2'h0, 2'h3, 1'b0, 1'b0));
        wr(T8OC_COMPARE_OFS, 32'h05);
        rchk("active", T8OC_ACTIVE_OFS, 32'h05);
        chk_bit("pin oe on", 1'b1, pin.oe);
        wr(T8OC_COUNT_OFS, 32'h05);
        rchk("blocked", T8OC_STATUS_OFS, 32'h4);
        step(1);
        rchk("no match", T8OC_STATUS_OFS, 32'h0);
        wr(T8OC_COUNT_OFS, 32'h04);
        step(2);
        rchk("match", T8OC_STATUS_OFS, 32'h3);
        chk_bit("irq off", 1'b0, irq);
        chk_bit("pin", 1'b1, pin.out);
        @(posedge clk);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        chk_bit("irq on", 1'b1, irq);
        wr(T8OC_STATUS_OFS, 32'h0);
        rchk("w1c zero", T8OC_STATUS_OFS, 32'h3);
        wr(T8OC_STATUS_OFS, 32'h1);
        rchk("w1c one", T8OC_STATUS_OFS, 32'h2);
        wr(T8OC_COUNT_OFS, 32'h04);
        step(2);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rchk("ack", T8OC_STATUS_OFS, 32'h2);
        chk_bit("irq ack", 1'b0, irq);
        e = 1'b1;
        for (int m = 0; m < 4; m += 2)
            for (int a = 0; a < 4; a++) begin
                wr(T8OC_CTRL_OFS, ctrl(m[1:0], a[1:0], 1'b1, ~e));
                e = (a == 1) ? ~e : (a == 2) ? 1'b0 : (a == 3) ? 1'b1 : e;
                exp_st = {30'h0, e, 1'b0};
                rchk("force", T8OC_STATUS_OFS, exp_st);
                chk_bit("pin src", (a == 0) ? ~e : e, pin.out);
            end
        rchk("count", T8OC_COUNT_OFS, 32'h06);
        wr(T8OC_CTRL_OFS, ctrl(2'h1, 2'h0, 1'b0, 1'b0));
        rchk("mode kept", T8OC_STATUS_OFS, 32'h2);
        wr(T8OC_CTRL_OFS, ctrl(2'h3, 2'h2, 1'b1, 1'b0));
        rchk("pwm force", T8OC_STATUS_OFS, 32'h2);
        wr(T8OC_CTRL_OFS, ctrl(2'h0, 2'h2, 1'b1, 1'b0));
        wr(T8OC_CTRL_OFS, ctrl(2'h3, 2'h2, 1'b0, 1'b0));
        wr(T8OC_COMPARE_OFS, 32'h20);
        rchk("buffered", T8OC_ACTIVE_OFS, 32'h05);
        wr(T8OC_COUNT_OFS, 32'hFE);
        step(2);
        rchk("copied", T8OC_ACTIVE_OFS, 32'h20);
        rchk("top set", T8OC_STATUS_OFS, 32'h2);
        wr(T8OC_COUNT_OFS, 32'h1E);
        step(3);
        rchk("noninv", T8OC_STATUS_OFS, 32'h1);
        wr(T8OC_CTRL_OFS, ctrl(2'h3, 2'h3, 1'b0, 1'b0));
        wr(T8OC_COUNT_OFS, 32'h1F);
        step(2);
        rchk("inverted", T8OC_STATUS_OFS, 32'h3);
        // phase correct, non-inverted: an upcounting match clears the state
        wr(T8OC_CTRL_OFS, ctrl(2'h1, 2'h2, 1'b0, 1'b0));
        wr(T8OC_COUNT_OFS, 32'h1F);
        step(2);
        rchk("pc upcount", T8OC_STATUS_OFS, 32'h1);
        final_report();
    end
endmodule // t8oc_unit_tb
`default_nettype wire
